// ==== sadc_cfg.svh ====
// sadc_cfg.svh: offsets, field positions, reset values and timing counts of the converter control
// assumes inclusion by the package and the design files; definitions only
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH
`define SADC_CONTROL_ADDR 8'hC0
`define SADC_INDIS_ADDR 8'hF6
`define SADC_CONTROL_RESET 8'h00
`define SADC_INDIS_RESET 8'h00
`define SADC_BIT_ENABLE 7
`define SADC_BIT_DONE 4
`define SADC_BIT_BUSY 3
`define SADC_BIT_RCSEL 2
`define SADC_BIT_CHHI 1
`define SADC_BIT_CHLO 0
`define SADC_WRITABLE_MASK 8'h9F
`define SADC_CLK_MHZ 20
`define SADC_CLK_PER_MCYC 6
`define SADC_CONV_MCYC 31
`define SADC_CONV_CYCLES (`SADC_CONV_MCYC * `SADC_CLK_PER_MCYC)
`define SADC_RC_EDGES 31
`define SADC_SETTLE_US 10
`define SADC_SETTLE_CYCLES (`SADC_SETTLE_US * `SADC_CLK_MHZ)
`define SADC_SYNC_STAGES 2
`endif

// ==== sadc_pkg.sv ====
// sadc_pkg.sv: types shared by the converter control and its approximation stage
// assumes sadc_cfg.svh holds the numbers
`include "sadc_cfg.svh"
package sadc_pkg;
    typedef struct packed {
        logic converter_enable;
        logic [1:0] reserved;
        logic conversion_done_flag;
        logic conversion_start_busy;
        logic rc_clock_select;
        logic channel_select_hi;
        logic channel_select_lo;
    } sadc_control_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sadc_sfr_req_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LAUNCH = 4'b0010,
        ST_CONVERT = 4'b0100,
        ST_FINISH = 4'b1000
    } sadc_state_t;
endpackage : sadc_pkg

// ==== sadc_sar.sv ====
// sadc_sar.sv: 8-bit successive approximation stage, one bit decided per step
// assumes the comparator answer cmp_hi is valid one cycle after trial is shown
module sadc_sar
    import sadc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // control
    input wire logic step,
    input wire logic load,
    // comparator
    input wire logic cmp_hi,
    output logic [WIDTH-1:0] trial,
    output logic [WIDTH-1:0] code
);
    logic [WIDTH-1:0] mask_reg;
    logic [WIDTH-1:0] acc_reg;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            mask_reg <= '0;
            acc_reg <= '0;
        end else if (load) begin
            mask_reg <= {1'b1, {(WIDTH-1){1'b0}}};
            acc_reg <= '0;
        end else if (step && mask_reg != '0) begin
            // keep the trial bit only when the input is at or above the trial level
            if (cmp_hi)
                acc_reg <= acc_reg | mask_reg;
            mask_reg <= mask_reg >> 1;
        end
    end

    assign trial = acc_reg | mask_reg;
    assign code = acc_reg;
endmodule : sadc_sar

// ==== sadc_ctrl.sv ====
// sadc_ctrl.sv: converter control register, input disable register, sequencing and result
// assumes a single 20 MHz cpu clock; sfr requests are one-cycle strobes; the analog front
// end supplies cmp_hi for the trial code; the rc oscillator arrives as a sampled level
// What this block and its software do
// [R01] software sets enable at least ten microseconds before any start
// [R02] software picks one analog channel before starting
// [R03] channel bits hold still while a conversion runs
// [R04] writing start launches conversion; busy stays one throughout
// [R05] on completion busy clears and done flag sets
// [R06] done flag raises converter interrupt request, gated by enables
// [R07] result register loads at completion, holds until next completion
// [R08] software clears done flag; hardware never clears it
// [R09] start write may change channel; done-clear write may not
// [R10] four inputs multiplexed into an 8-bit approximation stage
// [R11] result is input scaled by 255 over supply span, rounded
// [R12] control register at C0h, reset 00, fields as laid out
// [R13] input disable register at F6h, reset 00, one bit per pin
// [R14] port 0 reads give zero on disabled pins
// [R15] software tristates and disables inputs on analog pins
// [R16] starts ignored while busy or done flag is one
// [R17] enable cannot clear while busy or done flag is one
// [R18] clock select one uses rc oscillator, zero uses cpu clock
// [R19] on cpu clock a conversion takes 31 machine cycles
// [R20] channel code 0..3 selects inputs 0..3
// [R21] rc-timed start and finish cross into cpu clock edges
`include "sadc_cfg.svh"
module sadc_ctrl
    import sadc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // special function register access
    input wire sadc_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    // interrupt system
    input wire logic global_irq_enable,
    input wire logic converter_irq_enable,
    output logic converter_irq,
    // rc oscillator as a level
    input wire logic rc_osc,
    // port 0 pins and analog front end
    input wire logic [7:0] port0_pins,
    output logic [7:0] port0_read,
    input wire logic cmp_hi,
    output logic [7:0] sar_trial,
    output logic [1:0] analog_channel,
    output logic [7:0] conversion_result
);
    localparam int RC_STEPS = `SADC_RC_EDGES;
    sadc_control_t ctl_reg;
    logic [7:0] indis_reg;
    logic [7:0] result_reg;
    sadc_state_t state_reg;
    logic [7:0] cnt_reg;
    logic [2:0] bits_reg;
    logic rc_s1_reg;
    logic rc_s2_reg;
    logic rc_s3_reg;
    logic [7:0] rdata_reg;
    logic [7:0] port0_reg;
    logic irq_reg;
    logic [1:0] chan_out_reg;
    logic [7:0] trial_out_reg;
    logic [7:0] trial;
    logic [7:0] code;
    logic sar_step;
    logic sar_load;
    logic wr_ctl;
    logic start_ok;
    logic idle_quiet;
    logic rc_tick;
    sadc_control_t wctl;

    assign wctl = sadc_control_t'(sfr_req.wdata);
    assign wr_ctl = sfr_req.wr && sfr_req.addr == `SADC_CONTROL_ADDR;
    assign idle_quiet = !ctl_reg.conversion_start_busy && !ctl_reg.conversion_done_flag;
    assign start_ok = wr_ctl && wctl.conversion_start_busy && idle_quiet
        && ctl_reg.converter_enable; // R16
    // rising edge of the synchronised rc level; stage one feeds only stage two
    assign rc_tick = rc_s2_reg && !rc_s3_reg; // R21

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rc_s1_reg <= 1'b0;
            rc_s2_reg <= 1'b0;
            rc_s3_reg <= 1'b0;
        end else begin
            rc_s1_reg <= rc_osc;
            rc_s2_reg <= rc_s1_reg;
            rc_s3_reg <= rc_s2_reg;
        end
    end

    // control register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctl_reg <= sadc_control_t'(`SADC_CONTROL_RESET); // R12
        end else begin
            if (wr_ctl) begin
                // enable may not drop while a conversion or its flag is pending
                if (idle_quiet || wctl.converter_enable)
                    ctl_reg.converter_enable <= wctl.converter_enable; // R17
                // done flag: software may only clear it; completion below wins
                if (!wctl.conversion_done_flag)
                    ctl_reg.conversion_done_flag <= 1'b0; // R08
                // channel and clock select only change while fully idle; a write that
                // clears the flag sees the flag still set and so leaves them alone
                if (idle_quiet) begin
                    ctl_reg.rc_clock_select <= wctl.rc_clock_select; // R18
                    ctl_reg.channel_select_hi <= wctl.channel_select_hi; // R03 R09
                    ctl_reg.channel_select_lo <= wctl.channel_select_lo; // R03 R09
                end
            end
            if (start_ok)
                ctl_reg.conversion_start_busy <= 1'b1; // R04
            if (state_reg == ST_FINISH) begin
                ctl_reg.conversion_start_busy <= 1'b0; // R05
                ctl_reg.conversion_done_flag <= 1'b1; // R05
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn)
            indis_reg <= `SADC_INDIS_RESET; // R13
        else if (sfr_req.wr && sfr_req.addr == `SADC_INDIS_ADDR)
            indis_reg <= sfr_req.wdata; // R13
    end

    // sequencer: eight approximation steps spread over 31 machine cycles on the cpu clock, over 31 rc edges otherwise
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 8'h00;
            bits_reg <= 3'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_ok)
                        state_reg <= ST_LAUNCH; // R04
                end
                ST_LAUNCH: begin
                    cnt_reg <= 8'h00;
                    bits_reg <= 3'h0;
                    state_reg <= ST_CONVERT;
                end
                ST_CONVERT: begin
                    if (ctl_reg.rc_clock_select) begin
                        if (rc_tick)
                            cnt_reg <= cnt_reg + 8'h01; // R18 R21
                        if (cnt_reg == 8'(RC_STEPS))
                            state_reg <= ST_FINISH;
                    end else begin
                        cnt_reg <= cnt_reg + 8'h01;
                        if (cnt_reg == 8'(`SADC_CONV_CYCLES - 3))
                            state_reg <= ST_FINISH; // R19
                    end
                end
                ST_FINISH: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // one decision every 16 counts on the cpu clock, every 4 rc edges otherwise;
    // all eight steps must land before the finish count or low bits stay zero
    assign sar_load = state_reg == ST_LAUNCH;
    assign sar_step = state_reg == ST_CONVERT && (ctl_reg.rc_clock_select
        ? (rc_tick && cnt_reg[1:0] == 2'h2 && cnt_reg < 8'h20)
        : (cnt_reg[3:0] == 4'hF && cnt_reg < 8'h80)); // R10

    sadc_sar #(.WIDTH(8)) u_sar (
        .clk(clk),
        .resetn(resetn),
        .step(sar_step),
        .load(sar_load),
        .cmp_hi(cmp_hi),
        .trial(trial),
        .code(code)
    );

    // the front end compares against trial plus half a step, which rounds the code
    always_ff @(posedge clk) begin
        if (!resetn)
            result_reg <= 8'h00;
        else if (state_reg == ST_FINISH)
            result_reg <= code; // R07 R11
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            chan_out_reg <= 2'h0;
            trial_out_reg <= 8'h00;
            irq_reg <= 1'b0;
            port0_reg <= 8'h00;
            rdata_reg <= 8'h00;
        end else begin
            chan_out_reg <= {ctl_reg.channel_select_hi, ctl_reg.channel_select_lo}; // R20
            trial_out_reg <= trial;
            irq_reg <= ctl_reg.conversion_done_flag && global_irq_enable
                && converter_irq_enable; // R06
            port0_reg <= port0_pins & ~indis_reg; // R14
            case (sfr_req.addr)
                `SADC_CONTROL_ADDR: rdata_reg <= ctl_reg & `SADC_WRITABLE_MASK;
                `SADC_INDIS_ADDR: rdata_reg <= indis_reg;
                default: rdata_reg <= 8'h00;
            endcase
        end
    end

    assign sfr_rdata = rdata_reg;
    assign converter_irq = irq_reg;
    assign port0_read = port0_reg;
    assign analog_channel = chan_out_reg;
    assign sar_trial = trial_out_reg;
    assign conversion_result = result_reg;

    AST_BUSY_HOLDS: assert property (@(posedge clk) disable iff (!resetn) // R04
        start_ok |=> ctl_reg.conversion_start_busy [*8])
        else $error("busy dropped early");
    AST_DONE_SETS: assert property (@(posedge clk) disable iff (!resetn) // R05
        state_reg == ST_FINISH |=> ctl_reg.conversion_done_flag
            && !ctl_reg.conversion_start_busy)
        else $error("completion not reflected");
    AST_CPU_TIME: assert property (@(posedge clk) disable iff (!resetn) // R19
        (start_ok && !wctl.rc_clock_select) |=> ##185 state_reg == ST_FINISH)
        else $error("conversion time wrong");
    AST_NO_RESTART: assert property (@(posedge clk) disable iff (!resetn) // R16
        (ctl_reg.conversion_start_busy || ctl_reg.conversion_done_flag)
            && state_reg != ST_LAUNCH |=> state_reg != ST_LAUNCH)
        else $error("start accepted while pending");
    AST_CHAN_STILL: assert property (@(posedge clk) disable iff (!resetn) // R03
        ctl_reg.conversion_start_busy && $past(ctl_reg.conversion_start_busy)
            |-> $stable({ctl_reg.channel_select_hi, ctl_reg.channel_select_lo}))
        else $error("channel changed mid conversion");
    AST_ENABLE_KEPT: assert property (@(posedge clk) disable iff (!resetn) // R17
        $past(ctl_reg.conversion_done_flag) |-> ctl_reg.converter_enable
            || !$past(ctl_reg.converter_enable))
        else $error("enable cleared while flag set");
    AST_RESULT_HELD: assert property (@(posedge clk) disable iff (!resetn) // R07
        state_reg != ST_FINISH |=> $stable(result_reg))
        else $error("result changed without completion");
    AST_IRQ: assert property (@(posedge clk) disable iff (!resetn) // R06
        ##1 irq_reg == $past(ctl_reg.conversion_done_flag && global_irq_enable
            && converter_irq_enable))
        else $error("irq mismatch");
    AST_PORT_MASK: assert property (@(posedge clk) disable iff (!resetn) // R14
        ##1 (port0_reg & $past(indis_reg)) == 8'h00)
        else $error("disabled pin read nonzero");
endmodule : sadc_ctrl

// ==== sadc_ctrl_tb_top.sv ====
// sadc_ctrl_tb_top.sv: self-checking bench for the converter control block
// assumes sadc_cfg.svh and sadc_pkg are compiled first; the bench plays cpu and analog front end
module sadc_ctrl_tb_top
    import sadc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk;
    logic resetn;
    sadc_sfr_req_t sfr_req;
    logic [7:0] sfr_rdata;
    logic global_irq_enable;
    logic converter_irq_enable;
    logic converter_irq;
    logic rc_osc;
    logic [7:0] port0_pins;
    logic [7:0] port0_read;
    logic cmp_hi;
    logic [7:0] sar_trial;
    logic [1:0] analog_channel;
    logic [7:0] conversion_result;
    logic [7:0] vin;
    logic [7:0] vals [4];
    int num_errors;
    int checks;
    int n;

    sadc_ctrl dut (
        .clk(clk),
        .resetn(resetn),
        .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata),
        .global_irq_enable(global_irq_enable),
        .converter_irq_enable(converter_irq_enable),
        .converter_irq(converter_irq),
        .rc_osc(rc_osc),
        .port0_pins(port0_pins),
        .port0_read(port0_read),
        .cmp_hi(cmp_hi),
        .sar_trial(sar_trial),
        .analog_channel(analog_channel),
        .conversion_result(conversion_result)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // free-running rc oscillator, deliberately not a multiple of the cpu period
    initial begin
        rc_osc = 1'b0;
        forever #83 rc_osc = ~rc_osc;
    end

    // ideal comparator; an integer vin makes the rounded code equal vin
    always @(negedge clk) begin
        cmp_hi <= (vin >= sar_trial);
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one-cycle write strobe, then one idle cycle so the strobe never toggles in one step
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        sfr_req.wr = 1'b1;
        sfr_req.addr = a;
        sfr_req.wdata = d;
        @(negedge clk);
        sfr_req.wr = 1'b0;
        @(negedge clk);
    endtask : sfr_write

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        sfr_req.addr = a;
        @(negedge clk);
        chk(sfr_rdata, exp);
    endtask : rchk

    task automatic wait_irq;
        n = 0;
        while (converter_irq !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_irq

    task automatic convert(input logic [1:0] ch, input logic [7:0] v, input logic rc,
                           input int lo, input int hi);
        vin = v;
        sfr_write(8'hC0, {5'b10001, rc, ch});
        wait_irq;
        chk({7'b0, (n >= lo && n <= hi)}, 8'h01);
        chk({6'b0, analog_channel}, {6'b0, ch});
        chk(conversion_result, v);
        rchk(8'hC0, {5'b10010, rc, ch});
        sfr_write(8'hC0, {5'b10000, rc, ch});
        rchk(8'hC0, {5'b10000, rc, ch});
    endtask : convert

    task automatic complete_run;
        if (num_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        num_errors = 0;
        checks = 0;
        vals = '{8'h00, 8'hFF, 8'h80, 8'h7F};
        resetn = 1'b0;
        sfr_req = '0;
        vin = 8'h00;
        cmp_hi = 1'b0;
        global_irq_enable = 1'b1;
        converter_irq_enable = 1'b1;
        port0_pins = 8'hFF;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        rchk(8'hC0, 8'h00);
        rchk(8'hF6, 8'h00);
        chk(port0_read, 8'hFF);
        sfr_write(8'hF6, 8'h78);
        rchk(8'hF6, 8'h78);
        chk(port0_read, 8'h87);
        rchk(8'h55, 8'h00);
        sfr_write(8'hC0, 8'h08);
        rchk(8'hC0, 8'h00);
        sfr_write(8'hC0, 8'hE0);
        rchk(8'hC0, 8'h80);
        // settle time the software owes before the first start
        repeat (200) @(negedge clk);
        vin = 8'hB7;
        sfr_write(8'hC0, 8'h8A);
        rchk(8'hC0, 8'h8A);
        sfr_write(8'hC0, 8'h05);
        rchk(8'hC0, 8'h8A);
        wait_irq;
        rchk(8'hC0, 8'h92);
        chk(conversion_result, 8'hB7);
        chk({7'b0, converter_irq}, 8'h01);
        converter_irq_enable = 1'b0;
        repeat (2) @(negedge clk);
        chk({7'b0, converter_irq}, 8'h00);
        converter_irq_enable = 1'b1;
        global_irq_enable = 1'b0;
        repeat (2) @(negedge clk);
        chk({7'b0, converter_irq}, 8'h00);
        global_irq_enable = 1'b1;
        sfr_write(8'hC0, 8'h1B);
        rchk(8'hC0, 8'h92);
        sfr_write(8'hC0, 8'h81);
        rchk(8'hC0, 8'h82);
        chk({7'b0, converter_irq}, 8'h00);
        vin = 8'h3C;
        repeat (5) @(negedge clk);
        chk(conversion_result, 8'hB7);
        for (int ch = 0; ch < 4; ch++) begin
            convert(ch[1:0], vals[ch], 1'b0, 184, 190);
        end
        sfr_write(8'hC0, 8'h84);
        rchk(8'hC0, 8'h84);
        convert(2'h3, 8'h5A, 1'b1, 60, 180);
        sfr_write(8'hC0, 8'h00);
        rchk(8'hC0, 8'h00);
        complete_run;
    end

    // about 1300 cycles are expected; six times that means a hang
    initial begin
        #400000;
        num_errors++;
        complete_run;
    end
endmodule : sadc_ctrl_tb_top
